/* File: switch_pkg.sv */
package switch_pkg;

  // Serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int TOGGLE_POS = 15;
  localparam int ADDR_LSB = 9;
  localparam int ADDR_MSB = 12;
  localparam int DATA_BITS = 9;

  // Clock rate and timing figures
  localparam longint MCLK_HZ = 40000000;
  localparam longint TIMEOUT_MS = 310;
  localparam longint INPUT_LOW_MS = 250;
  localparam longint TIMEOUT_CYCLES = (TIMEOUT_MS * MCLK_HZ) / 1000;
  localparam longint INPUT_LOW_CYCLES = (INPUT_LOW_MS * MCLK_HZ) / 1000;

  // Register addresses
  localparam logic [3:0] ADDR_GLOBAL_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_GLOBAL_STATE = 4'h0;
  localparam logic [3:0] ADDR_FAULT_CH0 = 4'h2;
  localparam logic [3:0] ADDR_FAULT_CH1 = 4'h3;

  // Global configuration field positions
  localparam int CFG_SENSE_A = 0;
  localparam int CFG_SENSE_B = 1;
  localparam int CFG_WD_DISABLE = 2;
  localparam int CFG_TRACK_HOLD = 3;
  localparam logic [DATA_BITS-1:0] CFG_RESET = 9'h000;

  // Fault bits of one channel
  typedef struct packed {
    logic overcurrentFault;
    logic overheatFault;
    logic shortToSupply;
    logic severeShortFault;
    logic loadOpenWhenDriven;
    logic loadOpenWhenIdle;
  } chan_fault_t;

  // Device-wide faults
  typedef struct packed {
    logic clockFail;
    logic supplyHighFault;
    logic supplyLowFault;
  } glob_fault_t;

  // What the sense output presents
  typedef enum logic [1:0] {SENSE_OFF, SENSE_CH0, SENSE_CH1, SENSE_TEMP} sense_sel_t;

  typedef enum {MODE_SLEEP, MODE_NORMAL, MODE_FAILSAFE} mode_t;

endpackage

/* File: switch_control_pin_logic.sv */
`timescale 1ns/1ps

module switch_control_pin_logic #(
  parameter longint TIMEOUT_CYCLES = switch_pkg::TIMEOUT_CYCLES,
  parameter longint INPUT_LOW_CYCLES = switch_pkg::INPUT_LOW_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic serialClock,
  input wire logic serialIn,
  input wire logic chip_select_pin,
  output logic serialOut,
  output logic serialOutEnable,
  input wire logic reset_wake_pin,
  input wire logic [1:0] directIn,
  input wire logic [1:0] load_type_inputs,
  input wire logic logicSupplyOk,
  input wire logic [1:0] overcurrentWindow,
  input wire logic [1:0] switchedOn,
  input wire logic senseSettled,
  input wire switch_pkg::chan_fault_t faultCh0,
  input wire switch_pkg::chan_fault_t faultCh1,
  input wire switch_pkg::glob_fault_t faultGlobal,
  output switch_pkg::sense_sel_t senseSelect,
  output logic senseOutEnable,
  output logic senseHold,
  output logic senseReadyLow,
  output logic fault_status_pin,
  output logic [1:0] channelOn,
  output logic [1:0] motorProfile,
  output logic failSafe,
  output logic asleep
);

  // Count widths sized for the longest defaults
  localparam int CW = 24;

  // Synchronisers for slow pins into mclk
  logic [1:0] rstPinSync, csSync;
  logic [1:0] inSync0, inSync1, inPrev;
  logic rstPrev, csPrev;
  logic [1:0] typeMeta, typeSync; // Load-type pins, two stages

  // Frame hand-off from the link domain
  logic [switch_pkg::FRAME_BITS-1:0] frameLatched;
  logic frameToggle;
  logic [2:0] frameToggleSync;

  // Control state
  switch_pkg::mode_t mode;
  logic [switch_pkg::DATA_BITS-1:0] globalConfig;
  switch_pkg::chan_fault_t stickyCh0, stickyCh1;
  switch_pkg::glob_fault_t stickyGlob;
  logic [CW-1:0] wdCount, sleepCount;
  logic wdArmed, lastToggleBit;
  logic [switch_pkg::DATA_BITS-1:0] readMux;
  logic [switch_pkg::DATA_BITS-1:0] readWord;
  logic [3:0] readAddr;
  logic readStrobe;
  // Link logic clears on select high, and on system reset so the first frame never starts unknown
  wire linkClear = chip_select_pin | rst;

  // Address field of a frame
  function automatic logic [3:0] frameAddr(input logic [switch_pkg::FRAME_BITS-1:0] f);
    frameAddr = f[switch_pkg::ADDR_MSB:switch_pkg::ADDR_LSB];
  endfunction

  // Two flops on the reset, select, direct-input and load-type pins before use
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rstPinSync <= 2'h0;
      csSync <= 2'h3;
      inSync0 <= 2'h0;
      inSync1 <= 2'h0;
      typeMeta <= 2'h3;
      typeSync <= 2'h3;
    end else begin
      typeMeta <= load_type_inputs;
      typeSync <= typeMeta;
      rstPinSync <= {rstPinSync[0], reset_wake_pin};
      csSync <= {csSync[0], chip_select_pin};
      inSync0 <= {inSync0[0], directIn[0]};
      inSync1 <= {inSync1[0], directIn[1]};
    end
  end

  // Edge history taken only from second stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rstPrev <= 1'b0;
      csPrev <= 1'b1;
      inPrev <= 2'h0;
    end else begin
      rstPrev <= rstPinSync[1];
      csPrev <= csSync[1];
      inPrev <= {inSync1[1], inSync0[1]};
    end
  end

  // Link domain: shift in on falling serial clock, only while select is low
  logic [switch_pkg::FRAME_BITS-1:0] shiftIn;
  logic [4:0] bitCount;
  // Count stops one past a full frame so that long frames are refused too
  always_ff @(negedge serialClock or posedge linkClear) begin
    if (linkClear) begin
      bitCount <= 5'h00;
    end else begin
      shiftIn <= {shiftIn[switch_pkg::FRAME_BITS-2:0], serialIn};
      bitCount <= (bitCount > 5'(switch_pkg::FRAME_BITS)) ? bitCount : bitCount + 5'h01;
    end
  end

  // Select rising ends frame; capture only full frames and flag mclk side
  always_ff @(posedge chip_select_pin or posedge rst) begin
    if (rst) begin
      frameToggle <= 1'b0;
      frameLatched <= 16'h0000;
    end else if (bitCount == 5'(switch_pkg::FRAME_BITS)) begin
      frameLatched <= shiftIn;
      frameToggle <= ~frameToggle;
    end
  end

  // Output shift: load on first rising serial clock after select falls, shift out on later rising edges
  logic [switch_pkg::FRAME_BITS-1:0] shiftOut;
  logic outLoaded;
  always_ff @(posedge serialClock or posedge linkClear) begin
    if (linkClear) begin
      outLoaded <= 1'b0;
      shiftOut <= '0;
    end else if (!outLoaded) begin
      // Word was parked at select falling; first rising edge moves on
      shiftOut <= {2'h0, readAddr, 1'b0, readWord} << 1;
      outLoaded <= 1'b1;
    end else begin
      shiftOut <= shiftOut << 1;
    end
  end

  // Data pin: first bit valid at select low, later bits after rising clock
  always_comb begin
    serialOut = shiftOut[switch_pkg::FRAME_BITS-1];
  end
  // Enable follows select directly; host keeps clock low at select edges
  always_comb begin
    serialOutEnable = ~chip_select_pin;
  end

  // Frame arrival detect in mclk domain
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frameToggleSync <= 3'h0;
    end else begin
      frameToggleSync <= {frameToggleSync[1:0], frameToggle};
    end
  end
  wire frameDone = frameToggleSync[2] ^ frameToggleSync[1];

  // Read address comes from the previous frame; select fall reads it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readAddr <= switch_pkg::ADDR_GLOBAL_STATE;
    end else if (frameDone) begin
      readAddr <= frameAddr(frameLatched);
    end
  end

  // Read data word selected by address
  always_comb begin
    unique case (readAddr)
      switch_pkg::ADDR_GLOBAL_CONFIG: readMux = globalConfig;
      switch_pkg::ADDR_FAULT_CH0: readMux = {3'h0, stickyCh0};
      switch_pkg::ADDR_FAULT_CH1: readMux = {3'h0, stickyCh1};
      default: readMux = {3'h0, mode == switch_pkg::MODE_FAILSAFE, ~fault_status_pin, stickyGlob, 1'b0};
    endcase
  end

  // Register read word at select fall; the read clears the faults reported
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      readWord <= 9'h000;
      readStrobe <= 1'b0;
    end else begin
      readStrobe <= csPrev & ~csSync[1];
      if (csPrev & ~csSync[1]) begin
        readWord <= readMux;
      end
    end
  end

  // Sticky fault bits: new event wins over read-clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stickyCh0 <= '0;
      stickyCh1 <= '0;
      stickyGlob <= '0;
    end else if (!rstPinSync[1]) begin
      stickyCh0 <= '0;
      stickyCh1 <= '0;
      stickyGlob <= '0;
    end else begin
      stickyCh0 <= ((readStrobe && readAddr == switch_pkg::ADDR_FAULT_CH0) ? '0 : stickyCh0) | faultCh0;
      stickyCh1 <= ((readStrobe && readAddr == switch_pkg::ADDR_FAULT_CH1) ? '0 : stickyCh1) | faultCh1;
      stickyGlob <= ((readStrobe && readAddr == switch_pkg::ADDR_GLOBAL_STATE) ? '0 : stickyGlob) | faultGlobal;
    end
  end

  // Fault pin low while any fault bit stands
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fault_status_pin <= 1'b1;
    end else begin
      fault_status_pin <= ~(|stickyCh0 | |stickyCh1 | |stickyGlob);
    end
  end

  // Configuration register, held at reset value while reset pin low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      globalConfig <= switch_pkg::CFG_RESET;
    end else if (!rstPinSync[1]) begin
      globalConfig <= switch_pkg::CFG_RESET;
    end else if (frameDone && frameAddr(frameLatched) == switch_pkg::ADDR_GLOBAL_CONFIG) begin
      globalConfig <= frameLatched[switch_pkg::DATA_BITS-1:0];
    end
  end

  // Watchdog: toggle bit must change before timeout, else fail-safe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wdArmed <= 1'b0;
      wdCount <= '0;
      lastToggleBit <= 1'b0;
    end else if (rstPinSync[1] & ~rstPrev) begin
      wdArmed <= 1'b1;
      wdCount <= '0;
      lastToggleBit <= 1'b0;
    end else if (!rstPinSync[1] || globalConfig[switch_pkg::CFG_WD_DISABLE]) begin
      wdArmed <= 1'b0;
      wdCount <= '0;
    end else if (frameDone && frameLatched[switch_pkg::TOGGLE_POS] != lastToggleBit) begin
      lastToggleBit <= frameLatched[switch_pkg::TOGGLE_POS];
      wdCount <= '0;
    end else if (wdArmed && wdCount != CW'(TIMEOUT_CYCLES)) begin
      wdCount <= wdCount + CW'(1);
    end
  end

  // Input-low timer toward sleep while reset pin low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleepCount <= '0;
    end else if (rstPinSync[1] || inSync0[1] || inSync1[1]) begin
      sleepCount <= '0;
    end else if (sleepCount != CW'(INPUT_LOW_CYCLES)) begin
      sleepCount <= sleepCount + CW'(1);
    end
  end

  // Mode machine
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= switch_pkg::MODE_SLEEP;
    end else begin
      unique case (mode)
        switch_pkg::MODE_SLEEP: begin
          if ((rstPinSync[1] & ~rstPrev) || (|({inSync1[1], inSync0[1]} & ~inPrev))) begin
            mode <= switch_pkg::MODE_NORMAL;
          end
        end
        switch_pkg::MODE_NORMAL: begin
          if (sleepCount == CW'(INPUT_LOW_CYCLES)) begin
            mode <= switch_pkg::MODE_SLEEP;
          end else if (wdArmed && wdCount == CW'(TIMEOUT_CYCLES)) begin
            mode <= switch_pkg::MODE_FAILSAFE;
          end
        end
        switch_pkg::MODE_FAILSAFE: begin
          if (sleepCount == CW'(INPUT_LOW_CYCLES)) begin
            mode <= switch_pkg::MODE_SLEEP;
          end else if (rstPinSync[1] & ~rstPrev) begin
            mode <= switch_pkg::MODE_NORMAL;
          end
        end
      endcase
    end
  end

  // Channel drive and profile choice
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      channelOn <= 2'h0;
      motorProfile <= 2'h3;
    end else begin
      channelOn <= (mode == switch_pkg::MODE_SLEEP) ? 2'h0 : {inSync1[1], inSync0[1]};
      motorProfile <= typeSync;
    end
  end

  // Sense selection and output enable
  logic [1:0] selRaw;
  logic selChOn, selOc, senseAllowed;
  always_comb begin
    selRaw = {globalConfig[switch_pkg::CFG_SENSE_B], globalConfig[switch_pkg::CFG_SENSE_A]};
    selChOn = (selRaw == 2'(switch_pkg::SENSE_CH1)) ? switchedOn[1] : switchedOn[0];
    selOc = (selRaw == 2'(switch_pkg::SENSE_CH1)) ? overcurrentWindow[1] :
            (selRaw == 2'(switch_pkg::SENSE_CH0)) ? overcurrentWindow[0] : 1'b0;
    senseAllowed = (mode == switch_pkg::MODE_NORMAL) && logicSupplyOk;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      senseSelect <= switch_pkg::SENSE_OFF;
      senseOutEnable <= 1'b0;
      senseHold <= 1'b0;
    end else begin
      senseSelect <= switch_pkg::sense_sel_t'(selRaw);
      senseOutEnable <= (selRaw != 2'(switch_pkg::SENSE_OFF)) && senseAllowed && !selOc;
      // Hold last value while the sensed channel is off
      senseHold <= globalConfig[switch_pkg::CFG_TRACK_HOLD] && !selChOn;
    end
  end

  // Sense-ready: low when settled, released at any turn-off
  logic [1:0] onPrev;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      onPrev <= 2'h0;
      senseReadyLow <= 1'b0;
    end else begin
      onPrev <= switchedOn;
      if (|(onPrev & ~switchedOn)) begin
        senseReadyLow <= 1'b0;
      end else if (senseSettled && senseOutEnable) begin
        senseReadyLow <= 1'b1;
      end
    end
  end

  // Mode flags out
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      failSafe <= 1'b0;
      asleep <= 1'b1;
    end else begin
      failSafe <= mode == switch_pkg::MODE_FAILSAFE;
      asleep <= mode == switch_pkg::MODE_SLEEP;
    end
  end

endmodule // switch_control_pin_logic

/* File: spi_host_model.sv */
`timescale 1ns/1ps
// Host side of the serial port; its clock runs inside a frame and in the stray burst with select high
module spi_host_model (
  output logic serialClock,
  output logic serialIn,
  output logic chip_select_pin,
  input wire logic serialOut
);
  logic toggle; // Watchdog toggle bit, flipped every frame
  initial begin
    serialClock = 1'b0;
    serialIn = 1'b0;
    chip_select_pin = 1'b1;
    toggle = 1'b0;
  end
  // One whole frame; rx gathers the bits seen on falling edges
  task automatic xfer(input logic [3:0] a, input logic [8:0] d, output logic [15:0] rx);
    logic [15:0] w;
    toggle = ~toggle;
    w = {toggle, 2'h0, a, d};
    rx = 16'h0000;
    chip_select_pin = 1'b0;
    #1000;
    for (int i = 15; i >= 0; i--) begin
      #3 serialIn = w[i];
      #3 serialClock = 1'b1;
      #6 serialClock = 1'b0;
      rx = {rx[14:0], serialOut};
    end
    #60 chip_select_pin = 1'b1;
    serialIn = 1'b0; // Pull-down level once released
    #1000;
  endtask
  // Clock burst with select high, which the device must ignore
  task automatic stray();
    for (int i = 0; i < 16; i++) begin
      #3 serialIn = i[0];
      #3 serialClock = 1'b1;
      #6 serialClock = 1'b0;
    end
    serialIn = 1'b0;
  endtask
endmodule // spi_host_model

/* File: switch_control_pin_logic_asserts.sv */
`timescale 1ns/1ps
// Port-level relations of the switch control logic
module switch_control_pin_logic_asserts #(
  parameter longint TIMEOUT_CYCLES = 200,
  parameter longint INPUT_LOW_CYCLES = 100
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chip_select_pin,
  input wire logic serialOutEnable,
  input wire logic reset_wake_pin,
  input wire logic [1:0] directIn,
  input wire logic [1:0] load_type_inputs,
  input wire logic [1:0] overcurrentWindow,
  input wire logic [1:0] switchedOn,
  input wire switch_pkg::chan_fault_t faultCh0,
  input wire switch_pkg::sense_sel_t senseSelect,
  input wire logic senseOutEnable,
  input wire logic senseHold,
  input wire logic senseReadyLow,
  input wire logic fault_status_pin,
  input wire logic [1:0] channelOn,
  input wire logic [1:0] motorProfile,
  input wire logic failSafe,
  input wire logic asleep
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_outEn; serialOutEnable == !chip_select_pin; endproperty
  a_outEn: assert property (p_outEn) else $error("output enable differs from select");
  property p_senseOff; senseSelect == switch_pkg::SENSE_OFF |-> !senseOutEnable; endproperty
  a_senseOff: assert property (p_senseOff) else $error("sense driven while off");
  // Two cycles of grace for the registered enable
  property p_failSafe; failSafe && $past(failSafe, 2) |-> !senseOutEnable; endproperty
  a_failSafe: assert property (p_failSafe) else $error("sense driven in fail-safe");
  property p_overCur; (senseSelect == switch_pkg::SENSE_CH0 && overcurrentWindow[0])[*4] |-> !senseOutEnable; endproperty
  a_overCur: assert property (p_overCur) else $error("sense driven in over-current window");
  property p_profile; $stable(load_type_inputs)[*5] |-> motorProfile == load_type_inputs; endproperty
  a_profile: assert property (p_profile) else $error("profile differs from load type");
  // Fault bits only count once the wake pin has settled high
  property p_fault; reset_wake_pin && $past(reset_wake_pin, 4) && |faultCh0 |-> ##[1:4] !fault_status_pin; endproperty
  a_fault: assert property (p_fault) else $error("fault pin not pulled low");
  property p_resetHold; (!reset_wake_pin)[*6] |-> fault_status_pin && senseSelect == switch_pkg::SENSE_OFF; endproperty
  a_resetHold: assert property (p_resetHold) else $error("state not held at reset");
  property p_wake; $rose(reset_wake_pin) |-> ##[1:6] !asleep; endproperty
  a_wake: assert property (p_wake) else $error("no wake on reset pin rise");
  property p_direct; (!failSafe && !asleep && $stable(directIn))[*6] |-> channelOn == directIn; endproperty
  a_direct: assert property (p_direct) else $error("channel differs from direct input");
  property p_release; $fell(switchedOn[0]) && senseSelect == switch_pkg::SENSE_CH0 |-> ##[1:4] !senseReadyLow; endproperty
  a_release: assert property (p_release) else $error("ready not released at turn-off");
  property p_sleep; (asleep && !reset_wake_pin && directIn == 2'h0)[*3] |=> asleep; endproperty
  a_sleep: assert property (p_sleep) else $error("left sleep without cause");
  c_failSafe: cover property ($rose(failSafe));
  c_hold: cover property (senseHold);
  c_fault: cover property ($fell(fault_status_pin));
endmodule // switch_control_pin_logic_asserts

bind switch_control_pin_logic switch_control_pin_logic_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .INPUT_LOW_CYCLES(INPUT_LOW_CYCLES)) i_chk (.*);

/* File: tb.sv */
`timescale 1ns/1ps
// Bench for the switch control logic, with shortened timers
module tb;
  localparam int TO = 2000; // Watchdog cycles, cut down for run time
  localparam int IL = 400; // Input-low cycles before sleep
  logic mclk;
  logic rst = 1'b1, rwake = 1'b0, supOk = 1'b1, settled = 1'b0;
  logic [1:0] dIn = 2'h0, ltype = 2'h3, ocw = 2'h0, swOn = 2'h0;
  switch_pkg::chan_fault_t fc0 = '0, fc1 = '0;
  switch_pkg::glob_fault_t fg = '0;
  logic so, soe, senseEn, hold, rdy, fsp, fs, slp, sclk, sin, csn;
  logic [1:0] chOn, motor;
  switch_pkg::sense_sel_t sel;
  logic [15:0] rx; // Bits seen by the host in the last frame
  int nFail = 0;
  int samplesChecked = 0;
  switch_control_pin_logic #(.TIMEOUT_CYCLES(TO), .INPUT_LOW_CYCLES(IL)) i_dut (
    .mclk(mclk), .rst(rst), .serialClock(sclk), .serialIn(sin), .chip_select_pin(csn),
    .serialOut(so), .serialOutEnable(soe), .reset_wake_pin(rwake), .directIn(dIn),
    .load_type_inputs(ltype), .logicSupplyOk(supOk), .overcurrentWindow(ocw), .switchedOn(swOn),
    .senseSettled(settled), .faultCh0(fc0), .faultCh1(fc1), .faultGlobal(fg), .senseSelect(sel),
    .senseOutEnable(senseEn), .senseHold(hold), .senseReadyLow(rdy), .fault_status_pin(fsp),
    .channelOn(chOn), .motorProfile(motor), .failSafe(fs), .asleep(slp));
  spi_host_model i_host (.serialClock(sclk), .serialIn(sin), .chip_select_pin(csn), .serialOut(so));
  // 40 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Closing report, shared by the main flow and any wait that runs out
  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return slp;
      1: return fs;
      2: return fsp;
      default: return rdy;
    endcase
  endfunction
  // Bounded wait on one output flag
  task automatic waitFor(input int w, input logic v, input int lim);
    int k;
    k = 0;
    while (pick(w) !== v && k < lim) begin
      tick(1);
      k++;
    end
    if (pick(w) !== v) begin
      chk("waitFlag", 16'(v), 16'(pick(w)));
      endOfTest();
    end
  endtask
  // Frame, then realign to the falling edge for the next drive
  task automatic frame(input logic [3:0] a, input logic [8:0] d);
    i_host.xfer(a, d, rx);
    tick(1);
  endtask
  initial begin
    tick(5);
    chk("faultPin", 16'h1, 16'(fsp));
    chk("motor", 16'h3, 16'(motor));
    rst = 1'b0;
    tick(8);
    chk("asleep", 16'h1, 16'(slp));
    for (int i = 0; i < 4; i++) begin
      ltype = 2'(i);
      tick(6);
      chk("motor", 16'(i), 16'(motor));
    end
    dIn = 2'h1;
    waitFor(0, 1'b0, 20);
    tick(6);
    chk("chOn", 16'h1, 16'(chOn));
    dIn = 2'h0;
    tick(IL / 2);
    chk("asleep", 16'h0, 16'(slp));
    chk("chOn", 16'h0, 16'(chOn));
    waitFor(0, 1'b1, IL);
    rwake = 1'b1;
    waitFor(0, 1'b0, 10);
    tick(300);
    // Every sense selection, read back through the following frame
    for (int s = 0; s < 4; s++) begin
      frame(switch_pkg::ADDR_GLOBAL_CONFIG, 9'(s));
      i_host.stray();
      frame(switch_pkg::ADDR_GLOBAL_STATE, 9'h000);
      chk("rdData", 16'(s), 16'(rx[9:1]));
      chk("rdAddr", 16'(switch_pkg::ADDR_GLOBAL_CONFIG), 16'(rx[14:11]));
      chk("sel", 16'(s), 16'(sel));
      chk("senseEn", 16'(s != 0), 16'(senseEn));
    end
    frame(switch_pkg::ADDR_GLOBAL_CONFIG, 9'h001);
    ocw = 2'h1;
    tick(6);
    chk("senseEn", 16'h0, 16'(senseEn));
    ocw = 2'h0;
    supOk = 1'b0;
    tick(6);
    chk("senseEn", 16'h0, 16'(senseEn));
    supOk = 1'b1;
    frame(switch_pkg::ADDR_GLOBAL_CONFIG, 9'h009);
    swOn = 2'h1;
    settled = 1'b1;
    waitFor(3, 1'b1, 20);
    swOn = 2'h0;
    waitFor(3, 1'b0, 6);
    tick(4);
    chk("hold", 16'h1, 16'(hold));
    settled = 1'b0;
    fc0.overheatFault = 1'b1;
    tick(1);
    fc0 = '0;
    waitFor(2, 1'b0, 10);
    frame(switch_pkg::ADDR_FAULT_CH0, 9'h000);
    frame(switch_pkg::ADDR_FAULT_CH0, 9'h000);
    chk("faultData", 16'h010, 16'(rx[9:1]));
    chk("faultPin", 16'h1, 16'(fsp));
    frame(switch_pkg::ADDR_GLOBAL_STATE, 9'h000);
    chk("faultData", 16'h000, 16'(rx[9:1]));
    rwake = 1'b0;
    tick(8);
    chk("sel", 16'h0, 16'(sel));
    rwake = 1'b1;
    tick(10);
    frame(switch_pkg::ADDR_GLOBAL_CONFIG, 9'h001);
    tick(TO - 300);
    chk("failSafe", 16'h0, 16'(fs));
    waitFor(1, 1'b1, 600);
    tick(4);
    chk("senseEn", 16'h0, 16'(senseEn));
    endOfTest();
  end
endmodule // tb
